/* File: hdl/sipo_shifter.sv */
// gated serial-in parallel-out shift register with a two-entry bit buffer
`timescale 1ns/1ps
`default_nettype none

// How it works
// - eight stages are fed by one serial bit, firstInput AND secondInput.
// - the serial bit is high only when both inputs are high.
// - a bit is taken only on a rising shiftClk; inputs are free otherwise.
// - each shift loads the gated bit into stage one and moves the rest up.
// - the old last-stage bit is dropped, one position per shift.
// - clear_n low while ce is high forces all stages to zero whatever shiftClk and data do.
// - with clear_n high and no shift, every stage keeps its level.
module sipo_shifter #(
    parameter int WIDTH = sipo_pkg::STAGES
) (
    input  wire logic             clk,
    input  wire logic             rst_b,
    input  wire logic             ce,
    input  wire logic             shiftClk,
    input  wire logic             firstInput,
    input  wire logic             secondInput,
    input  wire logic             clear_n,
    input  wire logic             shiftReady,
    output var  logic [WIDTH-1:0] stageOut,
    output var  logic             stageOneOut,
    output var  logic             lastStageOut,
    output var  logic             bufferReady
);
    // the stage word and its reset value are fixed at eight bits
    if (WIDTH != sipo_pkg::STAGES) begin : widthCheck
        $error("sipo_shifter: WIDTH must equal STAGES");
    end

    sipo_pkg::pins_t pinMeta;
    sipo_pkg::pins_t pinSync;
    logic            clkPrev;
    sipo_pkg::pins_t next_pinMeta;
    sipo_pkg::pins_t next_pinSync;
    logic            next_clkPrev;

    // pins come from another domain: two flops before any use
    always_comb begin
        next_pinMeta = pinMeta;
        next_pinSync = pinSync;
        next_clkPrev = clkPrev;
        if (ce) begin
            next_pinMeta = '{clearN: clear_n, shiftClk: shiftClk,
                             firstInput: firstInput,
                             secondInput: secondInput};
            next_pinSync = pinMeta;
            next_clkPrev = pinSync.shiftClk;
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            pinMeta <= sipo_pkg::PIN_RESET;
            pinSync <= sipo_pkg::PIN_RESET;
            clkPrev <= 1'b0;
        end else begin
            pinMeta <= next_pinMeta;
            pinSync <= next_pinSync;
            clkPrev <= next_clkPrev;
        end
    end

    logic clearing;
    logic riseSeen;
    logic serialBit;
    assign clearing  = ce && !pinSync.clearN;
    // data sampled with the same delay as the clock, so setup is kept
    assign riseSeen  = ce && pinSync.clearN && pinSync.shiftClk
                       && !clkPrev;
    assign serialBit = pinSync.firstInput & pinSync.secondInput;

    // two-entry buffer: a stalled receiver loses no bit until it is full
    logic             bufMem [sipo_pkg::BUF_DEPTH];
    logic             wrPtr;
    logic             rdPtr;
    logic [1:0]       count;
    logic             push;
    logic             pop;
    logic             next_bufMem [sipo_pkg::BUF_DEPTH];
    logic             next_wrPtr;
    logic             next_rdPtr;
    logic [1:0]       next_count;
    logic             next_bufferReady;
    logic [WIDTH-1:0] next_stageOut;

    // an edge arriving while full is dropped; bufferReady warns the host
    assign push = riseSeen && (count != 2'(sipo_pkg::BUF_DEPTH));
    assign pop  = ce && pinSync.clearN && (count != 2'h0) && shiftReady;

    always_comb begin
        next_bufMem = bufMem;
        next_wrPtr  = wrPtr;
        next_rdPtr  = rdPtr;
        next_count  = count;
        next_stageOut = stageOut;
        if (clearing) begin
            next_wrPtr    = 1'b0;
            next_rdPtr    = 1'b0;
            next_count    = sipo_pkg::COUNT_RESET;
            next_stageOut = sipo_pkg::STAGE_RESET;
        end else begin
            if (push) begin
                next_bufMem[wrPtr] = serialBit;
                next_wrPtr = ~wrPtr;
            end
            if (pop) begin
                next_rdPtr = ~rdPtr;
                // last stage falls off the top
                next_stageOut = {stageOut[WIDTH-2:0], bufMem[rdPtr]};
            end
            next_count = count + 2'(push) - 2'(pop);
        end
        next_bufferReady = (next_count != 2'(sipo_pkg::BUF_DEPTH));
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            bufMem[0]    <= 1'b0;
            bufMem[1]    <= 1'b0;
            wrPtr        <= 1'b0;
            rdPtr        <= 1'b0;
            count        <= sipo_pkg::COUNT_RESET;
            stageOut     <= sipo_pkg::STAGE_RESET;
            stageOneOut  <= 1'b0;
            lastStageOut <= 1'b0;
            bufferReady  <= 1'b1;
        end else begin
            bufMem       <= next_bufMem;
            wrPtr        <= next_wrPtr;
            rdPtr        <= next_rdPtr;
            count        <= next_count;
            stageOut     <= next_stageOut;
            // registered copies of the two end stages
            stageOneOut  <= next_stageOut[0];
            lastStageOut <= next_stageOut[WIDTH-1];
            bufferReady  <= next_bufferReady;
        end
    end

    sequence s_pop;
        pop;
    endsequence

    sequence s_push;
        push;
    endsequence

    sequence s_clear2;
        clearing ##1 clearing;
    endsequence

    property p_chain;
        @(posedge clk) disable iff (!rst_b)
        s_pop |=> stageOut[WIDTH-1:1] == $past(stageOut[WIDTH-2:0]);
    endproperty
    a_chain: assert property (p_chain)
        else $error("stages did not move up by one");

    property p_gate;
        @(posedge clk) disable iff (!rst_b)
        s_push |=> bufMem[$past(wrPtr)] ==
                   $past(pinSync.firstInput && pinSync.secondInput);
    endproperty
    a_gate: assert property (p_gate)
        else $error("buffered bit is not the and of both inputs");

    property p_edgeOnly;
        @(posedge clk) disable iff (!rst_b)
        !(ce && pinSync.shiftClk && !clkPrev) |-> !push;
    endproperty
    a_edgeOnly: assert property (p_edgeOnly)
        else $error("bit taken without a rising shift clock");

    property p_load;
        @(posedge clk) disable iff (!rst_b)
        s_pop |=> stageOut[0] == $past(bufMem[rdPtr]);
    endproperty
    a_load: assert property (p_load)
        else $error("stage one did not take the buffered bit");

    property p_drop;
        @(posedge clk) disable iff (!rst_b)
        s_pop |=> lastStageOut == $past(stageOut[WIDTH-2])
                  && stageOut[WIDTH-1] == $past(stageOut[WIDTH-2]);
    endproperty
    a_drop: assert property (p_drop)
        else $error("old last stage was not replaced by its neighbour");

    // one clearing cycle must already be enough, not only a long clear
    property p_clearNow;
        @(posedge clk) disable iff (!rst_b)
        clearing |=> stageOut == sipo_pkg::STAGE_RESET && count == 2'h0
                     && bufferReady;
    endproperty
    a_clearNow: assert property (p_clearNow)
        else $error("one clearing cycle did not zero the stages");

    property p_clear;
        @(posedge clk) disable iff (!rst_b)
        s_clear2 |=> stageOut == sipo_pkg::STAGE_RESET && count == 2'h0
                     && stageOneOut == 1'b0 && lastStageOut == 1'b0;
    endproperty
    a_clear: assert property (p_clear)
        else $error("clear did not zero every stage");

    property p_hold;
        @(posedge clk) disable iff (!rst_b)
        (!pop && !clearing) |=> $stable(stageOut);
    endproperty
    a_hold: assert property (p_hold)
        else $error("stage changed without a shift");

    property p_ends;
        @(posedge clk) disable iff (!rst_b)
        stageOneOut == stageOut[0] && lastStageOut == stageOut[WIDTH-1];
    endproperty
    a_ends: assert property (p_ends)
        else $error("end stage outputs disagree with the parallel word");
endmodule

`default_nettype wire

/* File: hdl/sipo_pkg.sv */
// constants and carrier types for the gated serial-in parallel-out shifter
package sipo_pkg;
    localparam int        STAGES       = 8;
    localparam int        SYNC_DEPTH   = 2;
    localparam int        BUF_DEPTH    = 2;
    localparam logic [7:0] STAGE_RESET = 8'h00;
    localparam logic [1:0] COUNT_RESET = 2'h0;
    localparam logic [3:0] PIN_RESET   = 4'h0;

    // pin group as sampled from the host
    typedef struct packed {
        logic clearN;
        logic shiftClk;
        logic firstInput;
        logic secondInput;
    } pins_t;
endpackage

/* File: dv/serial_host.sv */
// host model driving the shifter pins
`timescale 1ns/1ps
`default_nettype none
module serial_host (
    input  wire logic clk,
    output var  logic shiftClk,
    output var  logic firstInput,
    output var  logic secondInput,
    output var  logic clear_n
);
    initial begin
        shiftClk = 1'h0;
        firstInput = 1'h0;
        secondInput = 1'h0;
        clear_n = 1'h1;
    end
    // levels held 3 cycles so the synchroniser sees them
    task automatic send_bit(input logic a, input logic b);
        @(posedge clk);
        #1;
        firstInput = a;
        secondInput = b;
        shiftClk = 1'h1;
        repeat (3) @(posedge clk);
        #1;
        firstInput = ~a; // data moves away from the edge
        secondInput = ~b;
        shiftClk = 1'h0;
        repeat (3) @(posedge clk);
    endtask
    // second input held high so the gated bit follows the toggling
    task automatic wiggle_data(input int n);
        @(posedge clk);
        #1;
        secondInput = 1'h1;
        repeat (n) begin
            @(posedge clk);
            #1;
            firstInput = ~firstInput;
        end
    endtask
    task automatic set_clear(input logic level);
        @(posedge clk);
        #1;
        clear_n = level;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: dv/test_serial_in_parallel_out_shifter.sv */
// bench for the gated serial-in parallel-out shifter
`timescale 1ns/1ps
`default_nettype none
module test_serial_in_parallel_out_shifter;
    logic       clk;
    logic       rst_b;
    logic       ce;
    logic       shiftReady;
    wire logic  sClk;
    wire logic  inA;
    wire logic  inB;
    wire logic  clrN;
    logic [7:0] stageOut;
    logic       oneOut;
    logic       lastOut;
    logic       bufReady;
    logic [7:0] model;
    int         failCount;
    int         checksDone;
    serial_host i_host (.clk(clk), .shiftClk(sClk), .firstInput(inA),
        .secondInput(inB), .clear_n(clrN));
    sipo_shifter i_dut (.clk(clk), .rst_b(rst_b), .ce(ce), .shiftClk(sClk),
        .firstInput(inA), .secondInput(inB), .clear_n(clrN),
        .shiftReady(shiftReady), .stageOut(stageOut), .stageOneOut(oneOut),
        .lastStageOut(lastOut), .bufferReady(bufReady));
    task automatic chk(input string      n,
                       input logic [7:0] w,
                       input logic [7:0] s);
        checksDone++;
        if (s !== w) begin
            failCount++;
            $display("Error %s expected %h seen %h", n, w, s);
        end
    endtask
    task automatic chk_all();
        chk("stageOut", model, stageOut);
        chk("stageOneOut", {7'h0, model[0]}, {7'h0, oneOut});
        chk("lastStageOut", {7'h0, model[7]}, {7'h0, lastOut});
    endtask
    task automatic push(input logic a, input logic b);
        i_host.send_bit(a, b);
        model = {model[6:0], a & b};
    endtask
    task automatic t_gate();
        for (int i = 0; i < 12; i++) begin
            push(i[0] | i[2], i[1] | i[3]);
            chk_all();
        end
        $display("gate test done");
    endtask
    task automatic t_hold();
        i_host.wiggle_data(9);
        repeat (4) @(posedge clk);
        chk_all();
        $display("hold test done");
    endtask
    task automatic t_stall();
        @(posedge clk);
        #1;
        shiftReady = 1'h0;
        i_host.send_bit(1'h1, 1'h1);
        i_host.send_bit(1'h0, 1'h1);
        // third edge finds the buffer full and is lost
        i_host.send_bit(1'h1, 1'h1);
        chk_all();
        chk("bufferReady", 8'h00, {7'h0, bufReady});
        #1;
        shiftReady = 1'h1;
        model = {model[5:0], 2'h2};
        repeat (4) @(posedge clk);
        chk_all();
        chk("bufferReady", 8'h01, {7'h0, bufReady});
        $display("stall test done");
    endtask
    task automatic t_freeze();
        @(posedge clk);
        #1;
        ce = 1'h0;
        // the whole pulse falls while frozen, so it is never seen
        i_host.send_bit(1'h1, 1'h1);
        chk_all();
        @(posedge clk);
        #1;
        ce = 1'h1;
        repeat (4) @(posedge clk);
        chk_all();
        $display("freeze test done");
    endtask
    task automatic t_reset();
        @(posedge clk);
        #1;
        rst_b = 1'h0;
        model = 8'h00;
        repeat (2) @(posedge clk);
        chk_all();
        chk("bufferReady", 8'h01, {7'h0, bufReady});
        #1;
        rst_b = 1'h1;
        push(1'h1, 1'h1);
        chk_all();
        $display("reset test done");
    endtask
    task automatic t_clear();
        i_host.set_clear(1'h0);
        model = 8'h00;
        chk_all();
        i_host.send_bit(1'h1, 1'h1);
        chk_all();
        i_host.set_clear(1'h1);
        push(1'h1, 1'h1);
        chk_all();
        $display("clear test done");
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", checksDone, failCount);
        if (failCount == 0 && checksDone > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'h0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (3000) @(posedge clk);
        failCount++;
        stop_test();
    end
    initial begin
        rst_b = 1'h0;
        ce = 1'h1;
        shiftReady = 1'h1;
        model = 8'h00;
        failCount = 0;
        checksDone = 0;
        repeat (4) @(posedge clk);
        #1;
        rst_b = 1'h1;
        chk_all();
        t_gate();
        t_hold();
        t_stall();
        t_freeze();
        t_clear();
        t_reset();
        stop_test();
    end
endmodule
`default_nettype wire
